// ### hdl/keypad_entry.sv
// Purpose: keypad value entry, menu switching, password gate, display history
// Assumes: attribute inputs describe the screen shown on o_screen
// Notes: display values (integer, fraction, sign) pass to the renderer
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - at most eight entry fields per screen
// - confirm stores value and notifies host together
// - changing field discards partial entry
// - erase key clears value being entered
// - eight digits positive, seven when negative
// - per-field integer and fraction digit widths
// - arrow keys move framed cursor between fields
// - digits, point, signs, erase and confirm keys
// - digits after point go to fraction
// - overflowing part shifts left, oldest dropped
// - menu keys 1-4 switch screen locally
// - menu switch reports destination to host
// - password is four panel digits
// - password digits hidden, box cursor only
// - password checked on fourth digit
// - three failures set notify bit four
// - history screens logged with time, number, comment
// - screens without history attribute not logged
// - history holds at most 256 entries
// - full history keeps entries, drops new ones
module keypad_entry #(
	parameter int SCREEN_W = 10,
	parameter int COMMENT_W = 16,
	parameter int TIME_W = 32,
	parameter logic [9:0] RESET_SCREEN = 10'h000
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// panel keys
	input wire logic i_key_valid,
	input wire logic [4:0] i_key_code,
	// host screen-switch word
	input wire logic i_sw_valid,
	input wire logic [SCREEN_W-1:0] i_sw_screen,
	input wire logic i_sw_password,
	input wire logic [15:0] i_sw_pw_code,
	input wire logic [SCREEN_W-1:0] i_sw_pw_dest,
	// attributes of the shown screen
	input wire logic [3:0] i_field_count,
	input wire logic [31:0] i_field_int_w,
	input wire logic [23:0] i_field_frac_w,
	input wire logic [55:0] i_field_table,
	input wire logic i_scr_menu,
	input wire logic [3:0] i_menu_dest_en,
	input wire logic [4*SCREEN_W-1:0] i_menu_dest,
	input wire logic i_scr_history,
	input wire logic [COMMENT_W-1:0] i_scr_comment,
	input wire logic [TIME_W-1:0] i_time,
	// history read port
	input wire logic [7:0] i_hist_rd_addr,
	// display state
	output logic [SCREEN_W-1:0] o_screen,
	output logic [2:0] o_cursor_field,
	output logic o_entry_show,
	output logic [31:0] o_entry_int,
	output logic [27:0] o_entry_frac,
	output logic o_entry_neg,
	output logic o_pw_prompt,
	output logic [2:0] o_pw_boxes,
	// numeral table write
	output logic o_store_valid,
	output logic [6:0] o_store_table,
	output logic [31:0] o_store_int,
	output logic [27:0] o_store_frac,
	output logic o_store_neg,
	// host notification
	output logic o_value_note,
	output logic o_screen_note,
	output logic [SCREEN_W-1:0] o_screen_note_num,
	output logic [15:0] o_notify_bits,
	// history
	output logic [8:0] o_hist_count,
	output logic [TIME_W+SCREEN_W+COMMENT_W-1:0] o_hist_rd_data
);
	localparam int HW = TIME_W + SCREEN_W + COMMENT_W;

	keypad_entry_pkg::ctrl_state_e state, next_state;
	logic [2:0] sel;
	logic [31:0] ent_int;
	logic [27:0] ent_frac;
	logic ent_neg, in_frac;
	logic [15:0] pw_buf, pw_code;
	logic [SCREEN_W-1:0] pw_dest;
	logic [2:0] pw_cnt;
	logic [1:0] fails;
	logic store_pulse, scr_pulse, show_pend;
	logic [SCREEN_W-1:0] note_num;
	logic [8:0] hist_count;
	logic [HW-1:0] hist_mem [0:keypad_entry_pkg::HIST_DEPTH-1];
	logic [HW-1:0] hist_rd;

	// key decode
	wire key = i_key_valid && !i_sw_valid;
	wire is_digit = i_key_code <= keypad_entry_pkg::KEY_DIGIT_LAST;
	wire [3:0] nib = i_key_code[3:0];
	wire in_entry = state == keypad_entry_pkg::ST_ENTRY;
	wire in_pw = state == keypad_entry_pkg::ST_PASSWORD;
	wire has_fields = i_field_count != 4'h0;
	wire [3:0] last_field = (i_field_count > 4'h8) ? 4'h7 : i_field_count - 4'h1;
	wire arrow_prev = i_key_code == keypad_entry_pkg::KEY_UP || i_key_code == keypad_entry_pkg::KEY_LEFT;
	wire arrow_next = i_key_code == keypad_entry_pkg::KEY_DOWN || i_key_code == keypad_entry_pkg::KEY_RIGHT;
	wire arrow_key = key && in_entry && has_fields && (arrow_prev || arrow_next);
	wire [2:0] sel_prev = (sel == 3'h0) ? last_field[2:0] : sel - 3'h1;
	wire [2:0] sel_next = ({1'b0, sel} >= last_field) ? 3'h0 : sel + 3'h1;

	// menu decode
	wire menu_num = is_digit && nib >= 4'h1 && nib <= 4'h4;
	wire [1:0] menu_idx = 2'(nib - 4'h1);
	wire menu_key = key && in_entry && i_scr_menu && menu_num && i_menu_dest_en[menu_idx];
	wire [SCREEN_W-1:0] menu_dest = i_menu_dest[menu_idx*SCREEN_W +: SCREEN_W];

	// field widths of the selected field
	wire [3:0] int_w_cfg = i_field_int_w[{sel, 2'b00} +: 4];
	wire [2:0] frac_w = i_field_frac_w[sel*3 +: 3];
	wire [6:0] field_table = i_field_table[sel*7 +: 7];
	wire [3:0] int_w = (ent_neg && int_w_cfg == keypad_entry_pkg::MAX_INT_DIGITS)
		? keypad_entry_pkg::NEG_INT_DIGITS : int_w_cfg;
	wire [31:0] int_mask = (int_w >= 4'h8) ? 32'hffffffff : ~(32'hffffffff << {int_w, 2'b00});
	wire [27:0] frac_mask = ~(28'hfffffff << {frac_w, 2'b00});
	wire [31:0] int_shift = {ent_int[27:0], nib} & int_mask;
	wire [27:0] frac_shift = {ent_frac[23:0], nib} & frac_mask;
	wire [31:0] neg_int = {4'h0, ent_int[27:0]};

	// entry key classes
	wire ent_key = key && in_entry && has_fields && !menu_key && !(i_scr_menu && menu_num);
	wire dig_key = ent_key && is_digit;
	wire dot_key = ent_key && i_key_code == keypad_entry_pkg::KEY_DOT && frac_w != 3'h0;
	wire minus_key = ent_key && i_key_code == keypad_entry_pkg::KEY_MINUS;
	wire plus_key = ent_key && i_key_code == keypad_entry_pkg::KEY_PLUS;
	wire erase_key = ent_key && i_key_code == keypad_entry_pkg::KEY_ERASE;
	wire confirm_key = ent_key && i_key_code == keypad_entry_pkg::KEY_CONFIRM;

	// password decode
	wire locked = fails == keypad_entry_pkg::PW_TRIES;
	wire pw_dig = key && in_pw && is_digit && !locked;
	wire pw_erase = key && in_pw && i_key_code == keypad_entry_pkg::KEY_ERASE;
	wire [15:0] pw_full = {pw_buf[11:0], nib};
	wire pw_last = pw_dig && pw_cnt == keypad_entry_pkg::PW_DIGITS - 3'h1;
	wire pw_ok = pw_last && pw_full == pw_code;
	wire pw_bad = pw_last && pw_full != pw_code;
	wire [1:0] fails_inc = fails + 2'h1;

	// a screen change from any source
	wire host_plain = i_sw_valid && !i_sw_password;
	wire host_pw = i_sw_valid && i_sw_password;
	wire scr_change = host_plain || menu_key || pw_ok;
	wire [SCREEN_W-1:0] next_screen = host_plain ? i_sw_screen : (menu_key ? menu_dest : pw_dest);
	wire clear_entry = i_sw_valid || scr_change || arrow_key || erase_key || confirm_key;

	// history decode
	wire hist_full = hist_count == 9'(keypad_entry_pkg::HIST_DEPTH);
	wire hist_wr = show_pend && i_scr_history && !hist_full;

	// next control state
	always_comb
	begin
		next_state = state;
		unique case (state)
			keypad_entry_pkg::ST_ENTRY:
				if (host_pw)
					next_state = keypad_entry_pkg::ST_PASSWORD;
			keypad_entry_pkg::ST_PASSWORD:
				if (host_plain || pw_ok)
					next_state = keypad_entry_pkg::ST_ENTRY;
			default:
				next_state = keypad_entry_pkg::ST_ENTRY;
		endcase
	end

	// screen, cursor and state
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			state <= keypad_entry_pkg::ST_ENTRY;
			o_screen <= RESET_SCREEN;
			sel <= 3'h0;
			show_pend <= 1'b0;
		end
		else
		begin
			state <= next_state;
			show_pend <= scr_change;
			if (scr_change)
				o_screen <= next_screen;
			if (i_sw_valid || scr_change)
				sel <= 3'h0;
			else if (arrow_key)
				sel <= arrow_prev ? sel_prev : sel_next;
		end
	end

	// value being entered
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_resetn || clear_entry)
		begin
			ent_int <= 32'h00000000;
			ent_frac <= 28'h0000000;
			ent_neg <= 1'b0;
			in_frac <= 1'b0;
		end
		else if (dig_key && in_frac)
			ent_frac <= frac_shift;
		else if (dig_key)
			ent_int <= int_shift;
		else if (dot_key)
			in_frac <= 1'b1;
		else if (minus_key)
		begin
			ent_neg <= 1'b1;
			if (int_w_cfg == keypad_entry_pkg::MAX_INT_DIGITS)
				ent_int <= neg_int;
		end
		else if (plus_key)
			ent_neg <= 1'b0;
	end

	// numeral table write and host value report in one action
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			store_pulse <= 1'b0;
			o_store_table <= 7'h00;
			o_store_int <= 32'h00000000;
			o_store_frac <= 28'h0000000;
			o_store_neg <= 1'b0;
		end
		else
		begin
			store_pulse <= confirm_key;
			if (confirm_key)
			begin
				o_store_table <= field_table;
				o_store_int <= ent_int;
				o_store_frac <= ent_frac;
				o_store_neg <= ent_neg;
			end
		end
	end

	// password capture and failure count
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			pw_buf <= 16'h0000;
			pw_cnt <= 3'h0;
			fails <= 2'h0;
			pw_code <= 16'h0000;
			pw_dest <= '0;
		end
		else if (host_pw)
		begin
			pw_code <= i_sw_pw_code;
			pw_dest <= i_sw_pw_dest;
			pw_buf <= 16'h0000;
			pw_cnt <= 3'h0;
			fails <= 2'h0;
		end
		else if (pw_last || pw_erase)
		begin
			pw_buf <= 16'h0000;
			pw_cnt <= 3'h0;
			if (pw_ok)
				fails <= 2'h0;
			else if (pw_bad)
				fails <= fails_inc;
		end
		else if (pw_dig)
		begin
			pw_buf <= pw_full;
			pw_cnt <= pw_cnt + 3'h1;
		end
	end

	// host notification of screen and error flag
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_resetn)
		begin
			scr_pulse <= 1'b0;
			note_num <= '0;
			o_notify_bits <= keypad_entry_pkg::NOTIFY_RESET;
		end
		else
		begin
			scr_pulse <= menu_key;
			if (menu_key)
				note_num <= menu_dest;
			if (pw_bad && fails_inc == keypad_entry_pkg::PW_TRIES)
				o_notify_bits[keypad_entry_pkg::NOTIFY_PW_ERR_BIT] <= 1'b1;
			else if (host_pw || host_plain)
				o_notify_bits[keypad_entry_pkg::NOTIFY_PW_ERR_BIT] <= 1'b0;
		end
	end

	// history store: one entry per shown history screen
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_resetn)
			hist_count <= 9'h000;
		else if (hist_wr)
			hist_count <= hist_count + 9'h001;
	end

	// history array write and registered read
	always_ff @(posedge i_sys_clk)
	begin
		if (hist_wr)
			hist_mem[hist_count[7:0]] <= {i_time, o_screen, i_scr_comment};
		hist_rd <= hist_mem[i_hist_rd_addr];
	end

	// outputs from flops
	assign o_cursor_field = sel;
	assign o_entry_show = in_entry;
	assign o_entry_int = ent_int;
	assign o_entry_frac = ent_frac;
	assign o_entry_neg = ent_neg;
	assign o_pw_prompt = in_pw;
	assign o_pw_boxes = pw_cnt;
	assign o_store_valid = store_pulse;
	assign o_value_note = store_pulse;
	assign o_screen_note = scr_pulse;
	assign o_screen_note_num = note_num;
	assign o_hist_count = hist_count;
	assign o_hist_rd_data = hist_rd;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	a_cursor_in_range: assert property ({1'b0, o_cursor_field} <= last_field)
		else $error("cursor outside configured fields");
	a_confirm_stores: assert property (confirm_key |=> o_store_valid && o_store_int == $past(ent_int))
		else $error("confirm did not store value");
	a_move_discards: assert property (arrow_key |=> ent_int == 32'h0 && !in_frac)
		else $error("field change kept partial value");
	a_erase_clears: assert property (erase_key |=> ent_int == 32'h0 && ent_frac == 28'h0)
		else $error("erase left digits");
	a_neg_seven: assert property (ent_neg |-> ent_int[31:28] == 4'h0)
		else $error("negative value holds eight digits");
	a_pw_hidden: assert property (in_pw |-> !o_entry_show
		&& o_entry_int == 32'h0 && o_entry_frac == 28'h0)
		else $error("password digits shown");
	a_pw_auto_check: assert property (pw_last && !host_pw |=> pw_cnt == 3'h0)
		else $error("password not checked on fourth digit");
	a_pw_lockout: assert property (locked && in_pw |-> o_notify_bits[4]
		&& o_pw_boxes == 3'h0 && $stable(o_screen))
		else $error("lockout without error flag");
	a_menu_switch: assert property (menu_key |=> o_screen == $past(menu_dest) && o_screen_note
		&& o_screen_note_num == o_screen)
		else $error("menu key did not switch and report");
	a_hist_skip: assert property (show_pend && !i_scr_history |=> $stable(hist_count))
		else $error("non-history screen logged");
	a_hist_full: assert property (hist_full |=> hist_full)
		else $error("full history changed");

	c_value_stored: cover property (confirm_key ##1 o_store_valid);
	c_menu_switch: cover property (menu_key ##1 o_screen_note);
	c_pw_lockout: cover property (pw_bad ##1 o_notify_bits[4]);
	c_pw_success: cover property (pw_ok ##1 in_entry);
endmodule

`default_nettype wire

// ### hdl/keypad_entry_pkg.sv
// Purpose: shared constants for the keypad entry and password screen logic
// Assumes: keys arrive as one-cycle coded events
// Notes: key codes and widths are used by the design and the bench alike
package keypad_entry_pkg;
	// key codes: digits 0 to 9 use their own value
	localparam logic [4:0] KEY_DIGIT_LAST = 5'h09;
	localparam logic [4:0] KEY_DOT = 5'h0a;
	localparam logic [4:0] KEY_PLUS = 5'h0b;
	localparam logic [4:0] KEY_MINUS = 5'h0c;
	localparam logic [4:0] KEY_ERASE = 5'h0d;
	localparam logic [4:0] KEY_CONFIRM = 5'h0e;
	localparam logic [4:0] KEY_UP = 5'h0f;
	localparam logic [4:0] KEY_DOWN = 5'h10;
	localparam logic [4:0] KEY_LEFT = 5'h11;
	localparam logic [4:0] KEY_RIGHT = 5'h12;
	// entry limits
	localparam int MAX_FIELDS = 8;
	localparam logic [3:0] MAX_INT_DIGITS = 4'h8;
	localparam logic [3:0] NEG_INT_DIGITS = 4'h7;
	localparam int MAX_FRAC_DIGITS = 7;
	// menu keys 1 to 4
	localparam int MENU_KEYS = 4;
	// password
	localparam logic [2:0] PW_DIGITS = 3'h4;
	localparam logic [1:0] PW_TRIES = 2'h3;
	localparam int NOTIFY_PW_ERR_BIT = 4;
	localparam int NOTIFY_WIDTH = 16;
	// history store
	localparam int HIST_DEPTH = 256;
	// reset values
	localparam logic [15:0] NOTIFY_RESET = 16'h0000;
	// control states, one-hot
	typedef enum logic [1:0] {
		ST_ENTRY = 2'b01,
		ST_PASSWORD = 2'b10
	} ctrl_state_e;
endpackage

// ### bench/host_model.sv
// Purpose: host controller model writing the screen-switch word
// Assumes: bench raises i_cmd for one cycle per request
// Notes: idle word fields show inverted values so stale data is never trusted
`timescale 1ns/1ps
`default_nettype none
module host_model #(
	parameter int SCREEN_W = 10
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// requests from the bench
	input wire logic i_cmd,
	input wire logic [SCREEN_W-1:0] i_cmd_screen,
	input wire logic i_cmd_pw,
	input wire logic [15:0] i_cmd_code,
	input wire logic [SCREEN_W-1:0] i_cmd_dest,
	input wire logic [SCREEN_W-1:0] i_alt_screen,
	// device notification
	input wire logic [15:0] i_notify_bits,
	// screen-switch word
	output logic o_sw_valid,
	output logic [SCREEN_W-1:0] o_sw_screen,
	output logic o_sw_password,
	output logic [15:0] o_sw_pw_code,
	output logic [SCREEN_W-1:0] o_sw_pw_dest
);
	logic err_seen;
	// one word per request, alternative screen once on password error
	always_ff @(posedge i_sys_clk)
	begin
		err_seen <= i_resetn & i_notify_bits[4];
		o_sw_valid <= 1'b0;
		o_sw_screen <= ~o_sw_screen;
		o_sw_password <= ~o_sw_password;
		o_sw_pw_code <= ~o_sw_pw_code;
		o_sw_pw_dest <= ~o_sw_pw_dest;
		if (i_resetn && i_cmd)
		begin
			o_sw_valid <= 1'b1;
			o_sw_screen <= i_cmd_screen;
			o_sw_password <= i_cmd_pw;
			o_sw_pw_code <= i_cmd_code;
			o_sw_pw_dest <= i_cmd_dest;
		end
		else if (i_resetn && i_notify_bits[4] && !err_seen)
		begin
			o_sw_valid <= 1'b1;
			o_sw_screen <= i_alt_screen;
			o_sw_password <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: self-checking bench for keypad entry, menu, password and history
// Assumes: keys and host words are launched by nba on the rising edge
// Notes: field 0 has two integer and one fraction digit, others full width
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0, resetn = 1'b0, key_valid = 1'b0, cmd = 1'b0, cmd_pw = 1'b0;
	logic [4:0] key_code = 5'h00;
	logic [9:0] cmd_screen = 10'h000, cmd_dest = 10'h030, alt = 10'h014;
	logic [15:0] cmd_code = 16'h1234, comment = 16'hc0de, notify;
	logic sw_valid, sw_pw, show, neg, prompt, st_valid, st_neg, vnote, snote;
	logic [9:0] sw_screen, sw_dest, screen, note_num;
	logic [15:0] sw_code;
	logic menu = 1'b0, hist = 1'b0;
	logic [3:0] dest_en = 4'h4;
	logic [39:0] mdest = 40'h0_0210_0000;
	logic [31:0] tnow = 32'h0204_0832, e_int, st_int;
	logic [7:0] rd_addr = 8'h00;
	logic [2:0] cursor, boxes;
	logic [27:0] e_frac, st_frac;
	logic [6:0] st_table;
	logic [8:0] hcount;
	logic [57:0] hdata;
	int fail_count = 0, compares = 0;
	always #20 clk = ~clk;
	host_model #(.SCREEN_W(10)) host_u (.i_sys_clk(clk), .i_resetn(resetn), .i_cmd(cmd),
		.i_cmd_screen(cmd_screen), .i_cmd_pw(cmd_pw), .i_cmd_code(cmd_code),
		.i_cmd_dest(cmd_dest), .i_alt_screen(alt), .i_notify_bits(notify),
		.o_sw_valid(sw_valid), .o_sw_screen(sw_screen), .o_sw_password(sw_pw),
		.o_sw_pw_code(sw_code), .o_sw_pw_dest(sw_dest));
	keypad_entry dut_u (.i_sys_clk(clk), .i_resetn(resetn), .i_key_valid(key_valid),
		.i_key_code(key_code), .i_sw_valid(sw_valid), .i_sw_screen(sw_screen),
		.i_sw_password(sw_pw), .i_sw_pw_code(sw_code), .i_sw_pw_dest(sw_dest),
		.i_field_count(4'h8), .i_field_int_w(32'h8888_8882), .i_field_frac_w(24'hfffff9),
		.i_field_table(56'h305), .i_scr_menu(menu), .i_menu_dest_en(dest_en),
		.i_menu_dest(mdest), .i_scr_history(hist), .i_scr_comment(comment), .i_time(tnow),
		.i_hist_rd_addr(rd_addr), .o_screen(screen), .o_cursor_field(cursor),
		.o_entry_show(show), .o_entry_int(e_int), .o_entry_frac(e_frac), .o_entry_neg(neg),
		.o_pw_prompt(prompt), .o_pw_boxes(boxes), .o_store_valid(st_valid),
		.o_store_table(st_table), .o_store_int(st_int), .o_store_frac(st_frac),
		.o_store_neg(st_neg), .o_value_note(vnote), .o_screen_note(snote),
		.o_screen_note_num(note_num), .o_notify_bits(notify), .o_hist_count(hcount),
		.o_hist_rd_data(hdata));
	// compare one value and count it
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one key press, returns just after the answer edge
	task automatic key(input logic [4:0] k);
		@(posedge clk);
		key_valid <= 1'b1;
		key_code <= k;
		@(posedge clk);
		key_valid <= 1'b0;
		#1;
	endtask
	// host request, returns just after the device took it
	task automatic host(input logic [9:0] s, input logic p);
		@(posedge clk);
		cmd <= 1'b1;
		cmd_screen <= s;
		cmd_pw <= p;
		@(posedge clk);
		cmd <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic pw4(input logic [15:0] c);
		for (int i = 3; i >= 0; i--)
			key({1'b0, c[4*i +: 4]});
	endtask
	// typing, shift on overflow, fraction, confirm
	task automatic t_entry();
		key(5'h01);
		key(5'h02);
		check("int12", e_int, 32'h12);
		key(5'h03);
		check("int_shift", e_int, 32'h23);
		key(keypad_entry_pkg::KEY_DOT);
		key(5'h04);
		key(5'h05);
		check("frac_shift", e_frac, 28'h5);
		key(keypad_entry_pkg::KEY_CONFIRM);
		check("store", {st_valid, vnote, st_table, st_int}, {2'b11, 7'h05, 32'h23});
		check("store_frac", st_frac, 28'h5);
	endtask
	// erase, field change discards, wrap over eight fields
	task automatic t_erase_move();
		key(5'h09);
		key(keypad_entry_pkg::KEY_ERASE);
		check("erase", e_int, 32'h0);
		key(5'h07);
		key(keypad_entry_pkg::KEY_DOWN);
		check("move", {cursor, e_int}, {3'h1, 32'h0});
		key(keypad_entry_pkg::KEY_UP);
		key(keypad_entry_pkg::KEY_LEFT);
		check("wrap", cursor, 3'h7);
		key(keypad_entry_pkg::KEY_RIGHT);
		key(keypad_entry_pkg::KEY_DOWN);
		check("right_down", cursor, 3'h1);
	endtask
	// eight digits, then minus drops the top one
	task automatic t_negative();
		for (int d = 1; d <= 8; d++)
			key(5'(d));
		check("eight", e_int, 32'h1234_5678);
		key(keypad_entry_pkg::KEY_MINUS);
		check("seven", {neg, e_int}, {1'b1, 32'h0234_5678});
		key(keypad_entry_pkg::KEY_PLUS);
		check("plus", {neg, e_int}, {1'b0, 32'h0234_5678});
		key(keypad_entry_pkg::KEY_MINUS);
		key(keypad_entry_pkg::KEY_CONFIRM);
		check("store_neg", {st_valid, st_table, st_neg, st_int},
			{1'b1, 7'h06, 1'b1, 32'h0234_5678});
	endtask
	task automatic t_menu();
		@(posedge clk) menu <= 1'b1;
		key(5'h04);
		check("unassigned", {screen, e_int}, {10'h000, 32'h0});
		key(5'h03);
		check("menu", {screen, snote, note_num}, {10'h021, 1'b1, 10'h021});
		menu <= 1'b0;
	endtask
	task automatic t_password();
		host(10'h00a, 1'b1);
		check("prompt", {prompt, show}, 2'b10);
		for (int i = 1; i <= 3; i++)
			key(5'(i));
		check("boxes", {boxes, e_int}, {3'h3, 32'h0});
		key(5'h04);
		check("good", {screen, prompt}, {10'h030, 1'b0});
		host(10'h00a, 1'b1);
		key(5'h09);
		key(keypad_entry_pkg::KEY_ERASE);
		check("pw_erase", boxes, 3'h0);
		pw4(16'h9999);
		pw4(16'h9999);
		host(10'h00a, 1'b1);
		pw4(16'h9999);
		pw4(16'h9999);
		check("two_fail", notify[4], 1'b0);
		pw4(16'h9999);
		check("err_flag", {notify[4], screen}, {1'b1, 10'h030});
		repeat (3) tick();
		check("alt", {notify[4], screen}, {1'b0, 10'h014});
	endtask
	task automatic rd(input logic [7:0] a, input logic [9:0] s);
		@(posedge clk);
		rd_addr <= a;
		repeat (2) @(posedge clk);
		#1;
		check("hist_data", hdata, {tnow, s, comment});
	endtask
	task automatic t_history();
		host(10'h002, 1'b0);
		tick();
		check("no_attr", hcount, 9'h000);
		@(posedge clk) hist <= 1'b1;
		host(10'h005, 1'b0);
		tick();
		check("one", hcount, 9'h001);
		for (int i = 1; i < 256; i++)
			host(i[0] ? 10'h006 : 10'h008, 1'b0);
		tick();
		check("full", hcount, 9'h100);
		host(10'h007, 1'b0);
		repeat (2) tick();
		check("kept", hcount, 9'h100);
		rd(8'h00, 10'h005);
		rd(8'hff, 10'h006);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		t_entry();
		t_erase_move();
		t_negative();
		t_menu();
		t_password();
		t_history();
		results();
	end
	// watchdog well beyond the expected run of under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule
`default_nettype wire
